// >>> logic/sdc_burst_step.sv
`timescale 1ns/1ns
`default_nettype none
// Next column of a burst from the current one, or from the start column and beat when interleaved.
module sdc_burst_step
#(
    parameter int COLS = 8
)
(
    input  wire logic [COLS-1:0] col,
    input  wire logic [COLS-1:0] start,
    input  wire logic [2:0]      burst_len,
    input  wire logic            interleaved,
    input  wire logic [3:0]      beat,
    output logic      [COLS-1:0] next_col
);
    import sdc_pkg::*;
    logic [COLS-1:0] wrap_mask;
    logic [COLS-1:0] seq_col;
    logic [COLS-1:0] ilv_col;

    always_comb
    begin
        wrap_mask = '0;
        case (burst_len)
            3'h1:    wrap_mask = COLS'(1);
            3'h2:    wrap_mask = COLS'(3);
            3'h3:    wrap_mask = COLS'(7);
            3'h7:    wrap_mask = '1;
            default: wrap_mask = '0;
        endcase
        // Full page wraps around the whole row
        seq_col = (col & ~wrap_mask) | ((col + COLS'(1)) & wrap_mask); //RL10
        // Interleave: XOR beat index with start
        ilv_col = (start & ~wrap_mask)
                | ((start ^ COLS'(beat)) & wrap_mask); //RL10
        next_col = (interleaved && burst_len != BL_FULL_PAGE)
                 ? ilv_col : seq_col; //RL9
    end
endmodule
`default_nettype wire

// >>> logic/sdc_controller.sv
`timescale 1ns/1ns
`default_nettype none
// Power-up sequencer plus a simple one-request command port.
module sdc_controller
#(
    parameter int STABLE_WAIT = sdc_pkg::STABLE_CYCLES,
    parameter int GAP         = sdc_pkg::CMD_GAP
)
(
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    sdc_link_if.ctl                        link,
    input  wire logic [sdc_pkg::ADDR_W-1:0] mode_value,
    input  wire logic                      req_valid,
    input  wire logic [3:0]                req_cmd,
    input  wire logic [sdc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [sdc_pkg::BANK_W-1:0] req_bank,
    input  wire logic [sdc_pkg::DATA_W-1:0] req_data,
    input  wire logic                      req_mask,
    output logic                           req_ready,
    output logic                           init_done,
    output logic      [sdc_pkg::DATA_W-1:0] rd_data,
    output logic                           rd_valid
);
    import sdc_pkg::*;

    typedef enum logic [2:0]
    {
        CS_WAIT  = 3'b000,
        CS_CLOSE = 3'b001,
        CS_RENEW = 3'b010,
        CS_MODE  = 3'b011,
        CS_RUN   = 3'b100
    } sdc_cstate_type;

    sdc_cstate_type state_reg;
    logic [31:0]    wait_reg;
    logic [3:0]     renew_reg;
    logic           gap_done;

    assign gap_done  = (wait_reg == '0);
    assign req_ready = (state_reg == CS_RUN) && gap_done;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_reg      <= CS_WAIT;
            wait_reg       <= 32'(STABLE_WAIT);
            renew_reg      <= '0;
            init_done      <= 1'b0;
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_DESELECT;
            link.addr      <= '0;
            link.bank      <= '0;
            link.byte_mask <= 1'b0;
            link.dq_ctl    <= '0;
            link.dq_ctl_oe <= 1'b0;
        end
        else
        begin
            {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= CMD_IDLE;
            link.dq_ctl_oe <= 1'b0;
            if (!gap_done)
                wait_reg <= wait_reg - 32'h1; //RL23
            case (state_reg)
                CS_WAIT:
                begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n}
                        <= CMD_DESELECT; //RL1
                    if (gap_done)
                        state_reg <= CS_CLOSE;
                end
                CS_CLOSE:
                begin
                    {link.cs_n, link.ras_n, link.cas_n, link.we_n}
                        <= CMD_CLOSE; //RL2
                    link.addr[ADDR_TEN] <= 1'b1;
                    wait_reg  <= 32'(GAP);
                    state_reg <= CS_RENEW;
                end
                CS_RENEW:
                    if (gap_done)
                    begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n}
                            <= CMD_RENEW; //RL3
                        wait_reg  <= 32'(GAP);
                        renew_reg <= renew_reg + 4'h1;
                        if (renew_reg == 4'(INIT_RENEWS - 1))
                            state_reg <= CS_MODE;
                    end
                CS_MODE:
                    if (gap_done)
                    begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n}
                            <= CMD_LOAD_MODE; //RL4
                        link.addr <= mode_value;
                        wait_reg  <= 32'(GAP);
                        state_reg <= CS_RUN;
                    end
                CS_RUN:
                begin
                    init_done <= gap_done;
                    if (req_valid && gap_done)
                    begin
                        {link.cs_n, link.ras_n, link.cas_n, link.we_n}
                            <= req_cmd;
                        link.addr      <= req_addr;
                        link.bank      <= req_bank;
                        link.byte_mask <= req_mask; //RL22
                        link.dq_ctl    <= req_data;
                        link.dq_ctl_oe <= (req_cmd == CMD_STORE); //RL16
                        wait_reg       <= 32'(GAP); //RL15
                    end
                end
                default: state_reg <= CS_WAIT;
            endcase
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end
        else
        begin
            rd_valid <= link.dq_mem_oe;
            rd_data  <= link.dq_mem;
        end
    end
endmodule
`default_nettype wire

// >>> logic/sdc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sdc_link_if;
    import sdc_pkg::*;
    logic                cs_n;
    logic                ras_n;
    logic                cas_n;
    logic                we_n;
    logic [ADDR_W-1:0]   addr;
    logic [BANK_W-1:0]   bank;
    logic                byte_mask;
    logic [DATA_W-1:0]   dq_ctl;
    logic                dq_ctl_oe;
    logic [DATA_W-1:0]   dq_mem;
    logic                dq_mem_oe;

    modport mem
    (
        input  cs_n, ras_n, cas_n, we_n, addr, bank, byte_mask,
        input  dq_ctl, dq_ctl_oe,
        output dq_mem, dq_mem_oe
    );
    modport ctl
    (
        output cs_n, ras_n, cas_n, we_n, addr, bank, byte_mask,
        output dq_ctl, dq_ctl_oe,
        input  dq_mem, dq_mem_oe
    );
endinterface
`default_nettype wire

// >>> logic/sdc_memory.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// RL1: Controller holds deselect 200 us after power
// RL2: First command closes all banks
// RL3: Eight renew cycles during power-up
// RL4: Mode register loaded during power-up
// RL5: Decode commands from strobes and bit ten
// RL6: Load mode captures length, type, latency
// RL7: Mode kept until next load
// RL8: Fixed bursts count and stop themselves
// RL9: Full page wraps until halted
// RL10: Sequential adds one; interleaved scrambles
// RL11: Read data after latency; release after
// RL12: Bit 13 selects extended register load
// RL13: Open row in an idle bank
// RL14: New read, store, halt, close preempt burst
// RL15: Controller never stores over a read; the controller only waits GAP cycles after each command
// RL16: Store data taken with the command
// RL17: Bit ten closes bank after burst; a store ended early by single-store mode leaves it open
// RL18: No auto close in full page
// RL19: Deselect masks new commands only
// RL20: Bursts continue over idle cycles
// RL21: Halt truncates any burst
// RL22: Controller honours close timing, masks
// RL23: Controller spaces dependent commands
module sdc_memory
#(
    parameter int BANKS = 4,
    parameter int COLS  = sdc_pkg::COL_W
)
(
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    sdc_link_if.mem                        link,
    output logic      [2:0]                burst_len,
    output logic                           interleaved,
    output logic      [2:0]                read_latency,
    output logic                           single_store,
    output logic      [2:0]                partial_array_keep,
    output logic      [1:0]                temp_comp_selfrefresh,
    output logic      [BANKS-1:0]          bank_open,
    output logic      [7:0]                renew_count
);
    import sdc_pkg::*;

    typedef enum logic [1:0]
    {
        BUR_NONE  = 2'b00,
        BUR_READ  = 2'b01,
        BUR_STORE = 2'b10
    } sdc_burst_type;

    logic [DATA_W-1:0]     store_mem [0:BANKS-1][0:(1<<COLS)-1];
    logic [3:0]            cmd;
    logic                  bit_ten;
    sdc_burst_type         burst_reg;
    logic [COLS-1:0]       col_reg;
    logic [COLS-1:0]       start_reg;
    logic [BANK_W-1:0]     bank_reg;
    logic [3:0]            beat_reg;
    logic                  autoclose_reg;
    logic [COLS-1:0]       col_next;
    logic                  last_beat;
    logic                  new_access;
    logic                  preempt;
    logic [7:0]            rd_valid_pipe;
    logic [DATA_W-1:0]     rd_data_pipe [0:7];
    logic [3:0]            beats_total;

    function automatic logic [3:0] beats_of(input logic [2:0] bl);
        case (bl)
            3'h0:    beats_of = 4'h1;
            3'h1:    beats_of = 4'h2;
            3'h2:    beats_of = 4'h4;
            3'h3:    beats_of = 4'h8;
            default: beats_of = 4'h0;
        endcase
    endfunction

    // Deselect masks decoding but not a running burst
    assign cmd     = link.cs_n ? CMD_DESELECT
                   : {1'b0, link.ras_n, link.cas_n, link.we_n}; //RL5 RL19
    assign bit_ten = link.addr[ADDR_TEN]; //RL5
    assign new_access = (cmd == CMD_READ) || (cmd == CMD_STORE);
    assign preempt = new_access || cmd == CMD_HALT
                   || cmd == CMD_CLOSE; //RL14 RL21
    assign beats_total = beats_of(burst_len);
    assign last_beat = (burst_len != BL_FULL_PAGE)
                     && (beat_reg + 4'h1 >= beats_total); //RL8

    sdc_burst_step #(.COLS(COLS)) u_step
    (
        .col         (col_reg),
        .start       (start_reg),
        .burst_len   (burst_len),
        .interleaved (interleaved),
        .beat        (beat_reg + 4'h1),
        .next_col    (col_next)
    );

    // Mode register
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            burst_len    <= BL_DEFAULT;
            interleaved  <= 1'b0;
            read_latency <= RL_DEFAULT;
            single_store <= 1'b0;
        end
        else if (cmd == CMD_LOAD_MODE && !link.addr[EXT_SEL_HI]) //RL7
        begin
            burst_len    <= link.addr[MODE_BL_HI:MODE_BL_LO]; //RL6
            interleaved  <= link.addr[MODE_BT_BIT]; //RL6
            read_latency <= link.addr[MODE_RL_HI:MODE_RL_LO]; //RL6
            single_store <= link.addr[MODE_WB_BIT]; //RL6
        end
    end

    // Extended register
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            partial_array_keep    <= '0;
            temp_comp_selfrefresh <= '0;
        end
        else if (cmd == CMD_LOAD_MODE && link.addr[EXT_SEL_HI]
                 && !link.addr[EXT_SEL_LO]) //RL12
        begin
            partial_array_keep    <= link.addr[EXT_PAK_HI:EXT_PAK_LO];
            temp_comp_selfrefresh <= link.addr[EXT_TCS_HI:EXT_TCS_LO];
        end
    end

    // Bank state and renew count
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            bank_open   <= '0;
            renew_count <= '0;
        end
        else
        begin
            if (cmd == CMD_OPEN_ROW && !bank_open[link.bank]) //RL13
                bank_open[link.bank] <= 1'b1;
            if (cmd == CMD_CLOSE)
            begin
                if (bit_ten)
                    bank_open <= '0;
                else
                    bank_open[link.bank] <= 1'b0;
            end
            if (cmd == CMD_RENEW && renew_count != 8'hFF)
                renew_count <= renew_count + 8'h01;
            if (burst_reg != BUR_NONE && !preempt && last_beat
                && autoclose_reg)
                bank_open[bank_reg] <= 1'b0; //RL17
        end
    end

    // Burst engine
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            burst_reg     <= BUR_NONE;
            col_reg       <= '0;
            start_reg     <= '0;
            bank_reg      <= '0;
            beat_reg      <= '0;
            autoclose_reg <= 1'b0;
        end
        else if (new_access && bank_open[link.bank]) //RL14
        begin
            burst_reg     <= (cmd == CMD_READ) ? BUR_READ : BUR_STORE;
            col_reg       <= link.addr[COLS-1:0];
            start_reg     <= link.addr[COLS-1:0];
            bank_reg      <= link.bank;
            beat_reg      <= '0;
            autoclose_reg <= bit_ten
                          && burst_len != BL_FULL_PAGE; //RL17 RL18
        end
        else if (preempt)
            burst_reg <= BUR_NONE; //RL21
        else if (burst_reg != BUR_NONE) //RL20
        begin
            if (last_beat
                || (burst_reg == BUR_STORE && single_store))
                burst_reg <= BUR_NONE; //RL8
            else
            begin
                col_reg  <= col_next; //RL9
                beat_reg <= beat_reg + 4'h1;
            end
        end
    end

    // Store path: first word taken with the command
    always_ff @(posedge core_clk)
    begin
        if (new_access && cmd == CMD_STORE && bank_open[link.bank]
            && !link.byte_mask)
            store_mem[link.bank][link.addr[COLS-1:0]] <= link.dq_ctl; //RL16
        else if (burst_reg == BUR_STORE && !preempt && !link.byte_mask
                 && !(last_beat || single_store))
            store_mem[bank_reg][col_next] <= link.dq_ctl;
    end

    // Read pipeline: stage 1 is one cycle after the command
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            rd_valid_pipe <= '0;
        else
            rd_valid_pipe <= {rd_valid_pipe[6:0],
                              (new_access && cmd == CMD_READ
                               && bank_open[link.bank])
                              || (burst_reg == BUR_READ && !preempt
                                  && !last_beat)};
    end

    always_ff @(posedge core_clk)
    begin
        rd_data_pipe[0] <= (new_access && cmd == CMD_READ)
                         ? store_mem[link.bank][link.addr[COLS-1:0]]
                         : store_mem[bank_reg][col_next];
        for (int i = 1; i < 8; i++)
            rd_data_pipe[i] <= rd_data_pipe[i-1];
    end

    // Latency zero is treated as one
    logic [2:0] lat_idx;
    assign lat_idx = (read_latency == 3'h0) ? 3'h0 : read_latency - 3'h1;

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            link.dq_mem_oe <= 1'b0;
            link.dq_mem    <= '0;
        end
        else
        begin
            link.dq_mem_oe <= rd_valid_pipe[lat_idx]; //RL11
            link.dq_mem    <= rd_data_pipe[lat_idx];
        end
    end
endmodule
`default_nettype wire

// >>> logic/sdc_pkg.sv
package sdc_pkg;
    localparam int ADDR_W      = 14;
    localparam int DATA_W      = 16;
    localparam int BANK_W      = 2;
    localparam int COL_W       = 8;
    // Command encoding: {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
    localparam logic [3:0] CMD_OPEN_ROW  = 4'h3;
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_STORE     = 4'h4;
    localparam logic [3:0] CMD_IDLE      = 4'h7;
    localparam logic [3:0] CMD_HALT      = 4'h6;
    localparam logic [3:0] CMD_CLOSE     = 4'h2;
    localparam logic [3:0] CMD_RENEW     = 4'h1;
    localparam logic [3:0] CMD_DESELECT  = 4'hF;
    localparam int ADDR_TEN      = 10;
    // Mode and extended register field positions and values
    localparam int MODE_BL_LO    = 0;
    localparam int MODE_BL_HI    = 2;
    localparam int MODE_BT_BIT   = 3;
    localparam int MODE_RL_LO    = 4;
    localparam int MODE_RL_HI    = 6;
    localparam int MODE_WB_BIT   = 9;
    localparam int EXT_SEL_HI    = 13;
    localparam int EXT_SEL_LO    = 12;
    localparam int EXT_PAK_LO    = 0;
    localparam int EXT_PAK_HI    = 2;
    localparam int EXT_TCS_LO    = 3;
    localparam int EXT_TCS_HI    = 4;
    localparam logic [2:0] BL_FULL_PAGE  = 3'h7;
    localparam logic [2:0] RL_DEFAULT    = 3'h2;
    localparam logic [2:0] BL_DEFAULT    = 3'h3;
    // Power-up timing
    localparam int CLK_MHZ        = 250;
    localparam int STABLE_US      = 200;
    localparam int STABLE_CYCLES  = STABLE_US * CLK_MHZ;
    localparam int INIT_RENEWS    = 8;
    localparam int CMD_GAP        = 8;
endpackage

// >>> tb/sdc_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sdc_link_asserts
#(
    parameter int STABLE = 20
)
(
    input wire logic                       core_clk,
    input wire logic                       resetn,
    input wire logic                       cs_n,
    input wire logic                       ras_n,
    input wire logic                       cas_n,
    input wire logic                       we_n,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input wire logic                       dq_ctl_oe,
    input wire logic                       dq_mem_oe
);
    import sdc_pkg::*;
    logic [3:0] cmd;
    logic       quiet;
    logic       seen_reg;
    logic       loaded_reg;
    logic [3:0] renews_reg;
    logic       fullpage_reg;
    int         cyc_reg;

    assign cmd   = {cs_n, ras_n, cas_n, we_n};
    assign quiet = cs_n || cmd == CMD_IDLE;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            cyc_reg <= 0;
        else if (cyc_reg < STABLE)
            cyc_reg <= cyc_reg + 1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            seen_reg <= 1'b0;
        else if (!cs_n)
            seen_reg <= 1'b1;
    end

    // Only renews before the first mode load belong to power-up
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            loaded_reg <= 1'b0;
        else if (cmd == CMD_LOAD_MODE)
            loaded_reg <= 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            renews_reg <= 4'h0;
        else if (cmd == CMD_RENEW && !loaded_reg && renews_reg != 4'hF)
            renews_reg <= renews_reg + 4'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (!resetn)
            fullpage_reg <= 1'b0;
        else if (cmd == CMD_LOAD_MODE && !addr[EXT_SEL_HI])
            fullpage_reg <= (addr[MODE_BL_HI:MODE_BL_LO] == BL_FULL_PAGE);
    end

    sequence s_cmd;
        !cs_n && cmd != CMD_IDLE;
    endsequence
    sequence s_gap;
        quiet [*3];
    endsequence
    sequence s_read;
        cmd == CMD_READ;
    endsequence

    deselect_hold_a: assert property (cyc_reg < STABLE |-> cs_n)
        else $error("command decoder selected during power-up wait");
    first_close_a: assert property (!seen_reg && !cs_n |->
        cmd == CMD_CLOSE && addr[ADDR_TEN])
        else $error("first command is not close of all banks");
    eight_renew_a: assert property (cmd == CMD_LOAD_MODE && !loaded_reg |->
        renews_reg == 4'h8)
        else $error("mode load not preceded by eight renews");
    cmd_spacing_a: assert property (s_cmd |=> s_gap)
        else $error("dependent command issued too soon");
    no_fight_a: assert property (!(dq_ctl_oe && dq_mem_oe))
        else $error("both ends drive the data bus");
    store_data_a: assert property (cmd == CMD_STORE |-> dq_ctl_oe)
        else $error("store without data in the same cycle");
    store_start_a: assert property ($rose(dq_ctl_oe) |->
        cmd == CMD_STORE)
        else $error("controller drives data without a store");
    read_answer_a: assert property (s_read |-> ##[2:8] dq_mem_oe)
        else $error("read data did not appear in time");
    no_autoclose_a: assert property ((cmd == CMD_READ || cmd == CMD_STORE)
        && fullpage_reg |-> !addr[ADDR_TEN])
        else $error("auto close requested in full page mode");
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    import sdc_pkg::*;
    logic              core_clk   = 1'b0;
    logic              resetn     = 1'b0;
    logic [ADDR_W-1:0] mode_value = 14'h0030;
    logic              req_valid  = 1'b0;
    logic [3:0]        req_cmd    = CMD_IDLE;
    logic [ADDR_W-1:0] req_addr   = 14'h0000;
    logic [BANK_W-1:0] req_bank   = 2'h0;
    logic [DATA_W-1:0] req_data   = 16'h0000;
    logic              req_mask   = 1'b0;
    logic              req_ready, init_done, rd_valid, interleaved, single_store;
    logic [DATA_W-1:0] rd_data;
    logic [2:0]        burst_len, read_latency, partial_array_keep;
    logic [1:0]        temp_comp_selfrefresh;
    logic [3:0]        bank_open;
    logic [7:0]        renew_count;
    int                num_errors = 0;
    int                n_tests    = 0;
    int                cyc        = 0;
    int                first_cyc  = 0;
    int                taken_cyc  = 0;
    logic [31:0]       seed       = 32'h00000030;
    int                wcols [6]  = '{0, 1, 2, 3, 254, 255};
    logic [DATA_W-1:0] model [int];
    logic [DATA_W-1:0] got [$];

    sdc_link_if lnk();
    sdc_controller #(.STABLE_WAIT(20), .GAP(8)) i_sdc_controller (
        .core_clk(core_clk), .resetn(resetn), .link(lnk),
        .mode_value(mode_value), .req_valid(req_valid), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_bank(req_bank), .req_data(req_data),
        .req_mask(req_mask), .req_ready(req_ready), .init_done(init_done),
        .rd_data(rd_data), .rd_valid(rd_valid));
    sdc_memory #(.BANKS(4)) i_sdc_memory (
        .core_clk(core_clk), .resetn(resetn), .link(lnk),
        .burst_len(burst_len), .interleaved(interleaved),
        .read_latency(read_latency), .single_store(single_store),
        .partial_array_keep(partial_array_keep),
        .temp_comp_selfrefresh(temp_comp_selfrefresh),
        .bank_open(bank_open), .renew_count(renew_count));
    sdc_link_asserts #(.STABLE(20)) i_sdc_link_asserts (
        .core_clk(core_clk), .resetn(resetn), .cs_n(lnk.cs_n),
        .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n),
        .addr(lnk.addr), .dq_ctl_oe(lnk.dq_ctl_oe),
        .dq_mem_oe(lnk.dq_mem_oe));

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cyc++;
        if (rd_valid === 1'b1)
        begin
            if (got.size() == 0)
                first_cyc = cyc;
            got.push_back(rd_data);
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Request held from just after an edge until the edge that takes it
    task automatic send(input logic [3:0] c, input logic [ADDR_W-1:0] a,
                        input logic [BANK_W-1:0] b);
        int n;
        n = 0;
        @(posedge core_clk);
        #1;
        req_valid = 1'b1;
        req_cmd   = c;
        req_addr  = a;
        req_bank  = b;
        @(negedge core_clk);
        while (req_ready !== 1'b1 && n < 100)
        begin
            n++;
            @(negedge core_clk);
        end
        @(posedge core_clk);
        #1;
        taken_cyc = cyc;
        req_valid = 1'b0;
        chk("request taken", 32'h1, {31'h0, n < 100});
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input int col);
        seed     = xs(seed);
        req_data = seed[15:0];
        model[col] = seed[15:0];
        send(CMD_STORE, col[13:0], 2'h0);
    endtask

    // Sequential order wraps the page; interleaved flips low column bits
    task automatic beats(input int col, input int n, input logic il,
                         input logic exact);
        int c;
        repeat (30) @(posedge core_clk);
        #1;
        for (int i = 0; i < n; i++)
        begin
            c = il ? (col ^ i) : ((col + i) % 256);
            chk("beat", {16'h0, model[c]},
                i < got.size() ? {16'h0, got[i]} : 32'hFFFFFFFF);
        end
        if (exact)
            chk("beat count", n, got.size());
    endtask

    task automatic rd(input int col);
        got.delete();
        send(CMD_READ, col[13:0], 2'h0);
    endtask

    task print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #20000;
        num_errors++;
        print_verdict;
    end

    initial
    begin
        repeat (20) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 1000 && init_done !== 1'b1; i++)
            @(posedge core_clk);
        chk("renew count", 32'h8, renew_count);
        chk("banks idle", 32'h0, bank_open);
        chk("burst len", 32'h0, burst_len);
        chk("latency field", 32'h3, read_latency);
        chk("interleave", 32'h0, {interleaved, single_store});
        $display("done power-up");
        send(CMD_OPEN_ROW, 14'h0000, 2'h0);
        chk("open bank", 32'h1, bank_open);
        foreach (wcols[i])
            wr(wcols[i]);
        rd(2);
        beats(2, 1, 1'b0, 1'b1);
        chk("read latency", taken_cyc + 6, first_cyc);
        // Masked store must leave the old word in place
        seed      = xs(seed);
        req_data  = seed[15:0];
        req_mask  = 1'b1;
        send(CMD_STORE, 14'h0003, 2'h0);
        req_mask  = 1'b0;
        rd(3);
        beats(3, 1, 1'b0, 1'b1);
        $display("done single access");
        send(4'h9, 14'h0000, 2'h0);
        send(4'h8, 14'h0037, 2'h0);
        chk("masked renew", 32'h8, renew_count);
        chk("masked load", 32'h0, burst_len);
        send(CMD_RENEW, 14'h0000, 2'h0);
        chk("renew decode", 32'h9, renew_count);
        $display("done deselect");
        send(CMD_LOAD_MODE, 14'h003A, 2'h0);
        chk("interleave set", 32'h1, interleaved);
        rd(1);
        beats(1, 4, 1'b1, 1'b1);
        rd(2);
        beats(2, 4, 1'b1, 1'b1);
        send(CMD_LOAD_MODE, 14'h0032, 2'h0);
        rd(0);
        beats(0, 4, 1'b0, 1'b1);
        // Single-store mode: only the first word of a store lands
        send(CMD_LOAD_MODE, 14'h0232, 2'h0);
        chk("single store", 32'h1, single_store);
        wr(0);
        rd(0);
        beats(0, 4, 1'b0, 1'b1);
        $display("done burst order");
        send(CMD_LOAD_MODE, 14'h2015, 2'h0);
        chk("array keep", 32'h5, partial_array_keep);
        chk("temp comp", 32'h2, temp_comp_selfrefresh);
        chk("mode kept", 32'h2, burst_len);
        $display("done extended");
        send(CMD_LOAD_MODE, 14'h0037, 2'h0);
        rd(254);
        send(CMD_HALT, 14'h0000, 2'h0);
        beats(254, 6, 1'b0, 1'b0);
        chk("halted", 32'h1, {31'h0, got.size() < 24});
        $display("done full page");
        send(CMD_LOAD_MODE, 14'h0032, 2'h0);
        send(CMD_OPEN_ROW, 14'h0000, 2'h1);
        chk("two open", 32'h3, bank_open);
        send(CMD_READ, 14'h0400, 2'h1);
        repeat (20) @(posedge core_clk);
        chk("auto close", 32'h1, bank_open);
        $display("done auto close");
        print_verdict;
    end
endmodule
`default_nettype wire
